// ==== hdl/fpu_clear_pkg.sv ====
// Functional notes
// (RULE1) Only the 16-bit low word 0xe563, no operands, is the clear-all operation.
// (RULE2) Clear-all writes zero into all eight working registers at once.
// (RULE3) Clear-all leaves all seven status word flags unchanged.
// (RULE4) Clear-all completes in one cycle; the next instruction sees cleared registers.
// (RULE5) The zero written is the all-zeros 32-bit pattern, positive zero.
package fpu_clear_pkg;

  localparam int NUM_REGS = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int INSTR_W = 16;

  localparam logic [INSTR_W-1:0] CLEAR_ALL_OPCODE = 16'he563;
  localparam logic [DATA_W-1:0] ZERO_PATTERN = 32'h0000_0000;

  // register map, byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_REG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ISSUE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h28;
  localparam int REG_STRIDE = 4;

  // status word bit positions
  localparam int TEST_FLAG_BIT = 0;
  localparam int INT_ZERO_FLAG_BIT = 1;
  localparam int INT_NEGATIVE_FLAG_BIT = 2;
  localparam int FLOAT_ZERO_FLAG_BIT = 3;
  localparam int FLOAT_NEGATIVE_FLAG_BIT = 4;
  localparam int LATCHED_UNDERFLOW_FLAG_BIT = 5;
  localparam int LATCHED_OVERFLOW_FLAG_BIT = 6;

  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
  } instr_type;

  typedef struct packed {
    logic latched_overflow_flag;
    logic latched_underflow_flag;
    logic float_negative_flag;
    logic float_zero_flag;
    logic int_negative_flag;
    logic int_zero_flag;
    logic test_flag;
  } status_type;

  localparam status_type STATUS_RESET = '0;
  localparam instr_type INSTR_RESET = '0;

  typedef logic [NUM_REGS-1:0][DATA_W-1:0] reg_file_type;

endpackage : fpu_clear_pkg

// ==== hdl/fp_op_decoder.sv ====
`timescale 1ns/1ps
module fp_op_decoder (
  input wire fpu_clear_pkg::instr_type instr,
  output logic clear_all_fp_regs_op
);
  import fpu_clear_pkg::*;

  // exact match on all sixteen bits; no field of the word is a don't-care
  always_comb begin
    clear_all_fp_regs_op = instr.valid && (instr.word == CLEAR_ALL_OPCODE); // RULE1
  end

endmodule : fp_op_decoder

// ==== hdl/fpu_clear_all_top.sv ====
// The register addresses and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module fpu_clear_all_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fpu_clear_pkg::instr_type pipe_instr,
  input wire logic [fpu_clear_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [fpu_clear_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [fpu_clear_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output fpu_clear_pkg::status_type fpu_status_word,
  output fpu_clear_pkg::reg_file_type fp_working_register,
  output logic clear_done
);
  import fpu_clear_pkg::*;

  function automatic logic [DATA_W-1:0] be_merge(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0] be
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  logic waitrequest_q;
  logic waitrequest_d;
  logic [DATA_W-1:0] readdata_q;
  logic [DATA_W-1:0] readdata_d;
  logic wr_take;
  logic rd_latch;
  instr_type sw_issue_q;
  instr_type sw_issue_d;
  instr_type cur_instr;
  logic [DATA_W-1:0] issue_merged;
  logic clear_all_fp_regs_op;
  status_type status_q;
  status_type status_d;
  logic [DATA_W-1:0] count_q;
  logic [DATA_W-1:0] count_d;
  logic clear_done_q;
  logic clear_done_d;
  reg_file_type regs_view;

  // bus handshake: a read is latched while waitrequest is high, a write is taken once it drops, one cycle later
  always_comb begin
    wr_take = write && !waitrequest_q;
    rd_latch = read && waitrequest_q;
    waitrequest_d = !((read || write) && waitrequest_q);
  end

  // the pipeline has priority; a software-issued word waits until the pipeline is idle
  always_comb begin
    cur_instr = pipe_instr.valid ? pipe_instr : sw_issue_q;
    issue_merged = be_merge({16'h0000, sw_issue_q.word}, writedata, byteenable);
    sw_issue_d = sw_issue_q;
    if (!pipe_instr.valid) begin
      sw_issue_d.valid = 1'b0;
    end
    if (wr_take && address == OFS_ISSUE) begin
      sw_issue_d.valid = 1'b1;
      sw_issue_d.word = issue_merged[INSTR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_issue_q <= INSTR_RESET;
    end else begin
      sw_issue_q <= sw_issue_d;
    end
  end

  fp_op_decoder u_decoder (
    .instr(cur_instr),
    .clear_all_fp_regs_op(clear_all_fp_regs_op)
  );

  // working registers; the clear overrides a bus write to the same register in that cycle
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    localparam logic [ADDR_W-1:0] REG_ADDR = ADDR_W'(OFS_REG_BASE + i * REG_STRIDE);
    logic [DATA_W-1:0] reg_q;
    logic [DATA_W-1:0] reg_d;

    always_comb begin
      reg_d = reg_q;
      if (wr_take && address == REG_ADDR) begin
        reg_d = be_merge(reg_q, writedata, byteenable);
      end
      if (clear_all_fp_regs_op) begin
        reg_d = ZERO_PATTERN; // RULE2 RULE5
      end
    end

    // written this edge, visible to the very next instruction
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        reg_q <= REG_RESET;
      end else begin
        reg_q <= reg_d; // RULE4
      end
    end

    assign regs_view[i] = reg_q;
  end

  // status flags change only by a bus write; the clear has no path into them
  always_comb begin
    status_d = status_q; // RULE3
    if (wr_take && address == OFS_STATUS && byteenable[0]) begin
      status_d.test_flag = writedata[TEST_FLAG_BIT];
      status_d.int_zero_flag = writedata[INT_ZERO_FLAG_BIT];
      status_d.int_negative_flag = writedata[INT_NEGATIVE_FLAG_BIT];
      status_d.float_zero_flag = writedata[FLOAT_ZERO_FLAG_BIT];
      status_d.float_negative_flag = writedata[FLOAT_NEGATIVE_FLAG_BIT];
      status_d.latched_underflow_flag = writedata[LATCHED_UNDERFLOW_FLAG_BIT];
      status_d.latched_overflow_flag = writedata[LATCHED_OVERFLOW_FLAG_BIT];
    end
  end

  always_comb begin
    count_d = count_q;
    if (clear_all_fp_regs_op) begin
      count_d = count_q + 32'h0000_0001;
    end
    clear_done_d = clear_all_fp_regs_op;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q <= STATUS_RESET;
      count_q <= COUNT_RESET;
      clear_done_q <= 1'b0;
    end else begin
      status_q <= status_d;
      count_q <= count_d;
      clear_done_q <= clear_done_d;
    end
  end

  // read mux; a read latched in the clear's cycle returns the value before the clear
  always_comb begin
    readdata_d = readdata_q;
    if (rd_latch) begin
      readdata_d = UNMAPPED_READ;
      if (address < OFS_STATUS && address[1:0] == 2'b00) begin
        readdata_d = regs_view[address[4:2]];
      end else if (address == OFS_STATUS) begin
        readdata_d[TEST_FLAG_BIT] = status_q.test_flag;
        readdata_d[INT_ZERO_FLAG_BIT] = status_q.int_zero_flag;
        readdata_d[INT_NEGATIVE_FLAG_BIT] = status_q.int_negative_flag;
        readdata_d[FLOAT_ZERO_FLAG_BIT] = status_q.float_zero_flag;
        readdata_d[FLOAT_NEGATIVE_FLAG_BIT] = status_q.float_negative_flag;
        readdata_d[LATCHED_UNDERFLOW_FLAG_BIT] = status_q.latched_underflow_flag;
        readdata_d[LATCHED_OVERFLOW_FLAG_BIT] = status_q.latched_overflow_flag;
      end else if (address == OFS_ISSUE) begin
        readdata_d = {15'h0000, sw_issue_q.valid, sw_issue_q.word};
      end else if (address == OFS_COUNT) begin
        readdata_d = count_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
      readdata_q <= UNMAPPED_READ;
    end else begin
      waitrequest_q <= waitrequest_d;
      readdata_q <= readdata_d;
    end
  end

  assign waitrequest = waitrequest_q;
  assign readdata = readdata_q;
  assign fpu_status_word = status_q;
  assign fp_working_register = regs_view;
  assign clear_done = clear_done_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic status_bus_write;
  assign status_bus_write = wr_take && address == OFS_STATUS;

  // plain boolean twin of s_issue, for use inside boolean expressions
  logic clear_issue_now;
  assign clear_issue_now = cur_instr.valid && cur_instr.word == CLEAR_ALL_OPCODE;

  sequence s_issue;
    cur_instr.valid && cur_instr.word == CLEAR_ALL_OPCODE;
  endsequence

  sequence s_other;
    cur_instr.valid && cur_instr.word != CLEAR_ALL_OPCODE;
  endsequence

  sequence s_cleared;
    clear_done && fp_working_register == '0;
  endsequence

  property p_recognise;
    s_issue |=> clear_done && count_q == $past(count_q) + 32'h0000_0001;
  endproperty
  a_recognise: assert property (p_recognise) // RULE1
    else $error("clear-all encoding not executed");

  property p_other_encoding;
    s_other |=> !clear_done && count_q == $past(count_q);
  endproperty
  a_other_encoding: assert property (p_other_encoding) // RULE1
    else $error("other encoding treated as clear-all");

  property p_all_cleared;
    s_issue |=> s_cleared;
  endproperty
  a_all_cleared: assert property (p_all_cleared) // RULE2
    else $error("not all working registers cleared");

  property p_flags_kept;
    s_issue and !status_bus_write |=> $stable(fpu_status_word);
  endproperty
  a_flags_kept: assert property (p_flags_kept) // RULE3
    else $error("clear-all changed status flags");

  property p_single_cycle;
    s_issue ##1 (!clear_issue_now && !write) |=> !clear_done && $stable(fp_working_register);
  endproperty
  a_single_cycle: assert property (p_single_cycle) // RULE4
    else $error("clear-all did not complete in one cycle");

  property p_zero_pattern;
    clear_done |-> fp_working_register[0] == ZERO_PATTERN
      && fp_working_register[NUM_REGS-1] == ZERO_PATTERN
      && $countones(fp_working_register) == 0;
  endproperty
  a_zero_pattern: assert property (p_zero_pattern) // RULE5
    else $error("cleared register is not all zeros");

endmodule : fpu_clear_all_top

// ==== bench/cpu_issue_model.sv ====
`timescale 1ns/1ps
module cpu_issue_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic issue_go,
  input wire logic [15:0] issue_word,
  output fpu_clear_pkg::instr_type pipe_instr
);
  import fpu_clear_pkg::*;
  instr_type instr_q;
  instr_type instr_d;
  // idle word is scrambled every cycle so nothing may lean on a stale opcode
  always_comb begin
    instr_d.valid = issue_go;
    instr_d.word = issue_go ? issue_word : ~instr_q.word;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_q <= INSTR_RESET;
    end else begin
      instr_q <= instr_d;
    end
  end
  assign pipe_instr = instr_q;
endmodule : cpu_issue_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import fpu_clear_pkg::*;
  logic ref_clk, rst, read, write, waitrequest, clear_done, issue_go;
  logic [ADDR_W-1:0] address;
  logic [DATA_W-1:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [15:0] issue_word;
  instr_type pipe_instr;
  status_type fpu_status_word;
  reg_file_type fp_working_register;
  int miscompares = 0;
  int tests_run = 0;
  logic [15:0] near [4] = '{16'he562, 16'he593, 16'h6563, 16'he573};
  fpu_clear_all_top dut (.ref_clk(ref_clk), .rst(rst), .pipe_instr(pipe_instr),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .fpu_status_word(fpu_status_word), .fp_working_register(fp_working_register),
    .clear_done(clear_done));
  cpu_issue_model partner (.ref_clk(ref_clk), .rst(rst), .issue_go(issue_go),
    .issue_word(issue_word), .pipe_instr(pipe_instr));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    // no local limit: a hung slave is caught by the watchdog
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // the opcode executes two edges after the request: one in the model, one in the unit
  task automatic issue(input logic [15:0] w);
    @(posedge ref_clk);
    issue_word <= w;
    issue_go <= 1'b1;
    @(posedge ref_clk);
    issue_go <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : issue
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'hf;
    issue_go = 1'b0;
    issue_word = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, ADDR_W'(i * 4), 32'h0);
      chk("reg reset", rd, 32'h0000_0000);
      bus(1'b1, ADDR_W'(i * 4), 32'h1111_1111 * (i + 1));
    end
    bus(1'b1, OFS_STATUS, 32'h0000_007f);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count reset", rd, 32'h0000_0000);
    foreach (near[k]) begin
      issue(near[k]);
      chk("done on other word", clear_done, 1'b0);
      chk("reg3 kept", fp_working_register[3], 32'h4444_4444);
    end
    issue(16'he563);
    chk("done", clear_done, 1'b1);
    for (int i = 0; i < 8; i++) begin
      chk("reg cleared", fp_working_register[i], 32'h0000_0000);
    end
    chk("status kept", 32'(fpu_status_word), 32'h0000_007f);
    bus(1'b1, 8'h1c, 32'hbf80_0000);
    issue(16'he563);
    chk("reg7 cleared again", fp_working_register[7], 32'h0000_0000);
    bus(1'b0, 8'h1c, 32'h0);
    chk("reg7 bus read", rd, 32'h0000_0000);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("status bus read", rd, 32'h0000_007f);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count", rd, 32'h0000_0002);
    bus(1'b1, 8'h08, 32'h3f80_0000);
    bus(1'b1, OFS_ISSUE, 32'h0000_e563);
    // pipeline idle, so the pending word executes at the next edge
    @(posedge ref_clk);
    #1;
    chk("sw issue done", clear_done, 1'b1);
    chk("reg2 sw cleared", fp_working_register[2], 32'h0000_0000);
    @(posedge ref_clk);
    #1;
    chk("done one cycle", clear_done, 1'b0);
    bus(1'b0, OFS_ISSUE, 32'h0);
    chk("issue word read", rd, 32'h0000_e563);
    bus(1'b0, OFS_COUNT, 32'h0);
    chk("count sw", rd, 32'h0000_0003);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped read", rd, 32'h0000_0000);
    report_and_stop;
  end
endmodule : tb
